// ---- bench/capability_load_agu_assertions.sv ----
// Port checker for the capability load unit.
`timescale 1ns/10ps
`default_nettype none

module capability_load_agu_assertions #(
  parameter int ADDR_WIDTH = 64
) (
  // Clock, reset and register port.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  // Memory port, writeback and completion.
  input wire logic mem_req,
  input wire logic [ADDR_WIDTH-1:0] mem_addr,
  input wire logic [4:0] mem_bytes,
  input wire logic mem_cap,
  input wire logic mem_ack,
  input wire logic wb_gpr_en,
  input wire logic wb_cap_en,
  input wire logic wb_vec_en,
  input wire logic req_ready,
  input wire logic done,
  input wire logic fault
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Register port answers.
  a_pready_pulse: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready not a lone pulse");
  a_slverr_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_prdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero when idle");

  // Memory requests.
  a_cap_size: assert property (mem_req && mem_cap |-> mem_bytes == 5'h10)
    else $error("capability size not 16 bytes");
  a_mem_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("memory request not held");

  // Writeback and faults.
  a_ack_to_wb: assert property (mem_req && mem_ack |=> done && !fault && !mem_req
    && $onehot({wb_gpr_en, wb_cap_en, wb_vec_en}))
    else $error("no single writeback after answer");
  a_cap_wb: assert property (mem_req && mem_ack && mem_cap |=> wb_cap_en)
    else $error("no capability writeback");
  a_fault_no_wb: assert property (fault |-> done && !mem_req
    && !(wb_gpr_en || wb_cap_en || wb_vec_en))
    else $error("fault wrote or reached memory");
  a_done_ready: assert property (done |=> req_ready && !done)
    else $error("not ready after done");

  // Main scenarios reached.
  c_fault: cover property (fault);
  c_cap_wb: cover property (wb_cap_en);
  c_slverr: cover property (pslverr);
  c_irq: cover property (irq);
endmodule

bind capability_load_agu capability_load_agu_assertions #(.ADDR_WIDTH(ADDR_WIDTH))
  capability_load_agu_assertions_i (.pclk, .presetn, .psel, .penable, .prdata, .pready,
  .pslverr, .irq, .mem_req, .mem_addr, .mem_bytes, .mem_cap, .mem_ack, .wb_gpr_en,
  .wb_cap_en, .wb_vec_en, .req_ready, .done, .fault);

`default_nettype wire

// ---- bench/mem_partner.sv ----
// Memory system model that answers load requests promptly or slowly.
`timescale 1ns/10ps
`default_nettype none

module mem_partner (
  // Clock, reset and answer speed.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  // Memory port.
  input wire logic mem_req,
  input wire logic [63:0] mem_addr,
  output logic mem_ack,
  output logic [127:0] mem_rdata,
  output logic mem_rtag
);
  int cnt;

  // Answer after zero or four cycles; data churns outside an answer.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'h0;
      mem_rdata <= '0;
      mem_rtag <= 1'h0;
      cnt <= 0;
    end else if (mem_ack || !mem_req || cnt < (slow ? 4 : 0)) begin
      mem_ack <= 1'h0;
      mem_rdata <= ~mem_rdata;
      mem_rtag <= ~mem_rtag;
      cnt <= mem_req && !mem_ack ? cnt + 1 : 0;
    end else begin
      mem_ack <= 1'h1;
      mem_rdata <= {~mem_addr, mem_addr ^ 64'h5a5a_0f0f_c3c3_9696};
      mem_rtag <= mem_addr[4];
    end
  end
endmodule

`default_nettype wire

// ---- bench/test_capability_load_agu.sv ----
// Self-checking bench for the capability load unit.
`timescale 1ns/10ps
`default_nettype none

module test_capability_load_agu;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic ces, uao, e2h, tge, cen, fpe;
  logic req_valid = 1'h0, sg, wd, sh, dw, slow = 1'h0;
  logic bt, dt, pready, pslverr, irq, req_ready, mem_req, mem_cap;
  logic mem_unpriv, mem_ack, mem_rtag, wb_gpr_en, wb_cap_en, wb_vec_en, wb_tag, done, fault;
  logic ib, ok, ef, er, seen, bad, cap, rtag;
  logic [1:0] el, mem_cap_level;
  logic [2:0] op = '0, vsc;
  logic [3:0] ebit;
  logic [4:0] dest, rm, mem_bytes, wb_index, nb;
  logic [8:0] imm;
  logic [11:0] paddr = '0;
  logic [15:0] bp, dp;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [63:0] ov, gb, cb, lo = 64'h0fff_0000, hi, mem_addr;
  logic [63:0] seed = 64'h63, r, base, off, addr;
  logic [127:0] mem_rdata, wb_data, rdat, ed;
  int failures = 0, num_checks = 0, n, cnt = 0;

  always #5 pclk = ~pclk;

  capability_load_agu #(.ADDR_WIDTH(64)) capability_load_agu_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .irq, .capability_exec_state(ces), .user_access_override(uao),
    .host_extension_enable(e2h), .trap_general_exceptions(tge), .exec_level(el),
    .caps_enabled(cen), .fp_enabled(fpe), .req_valid, .req_ready, .req_op(op),
    .dest_field(dest), .offset_reg_field(rm), .nine_bit_immediate(imm), .ext_sign_bit(sg),
    .offset_width_bit(wd), .shift_bit(sh), .dword_class(dw), .vec_size_class(vsc),
    .offset_reg_value(ov), .base_gpr_value(gb), .base_cap_addr(cb), .base_cap_lower(lo),
    .base_cap_upper(hi), .base_cap_perms(bp), .base_cap_tag(bt), .ddc_lower(lo),
    .ddc_upper(hi), .ddc_perms(dp), .ddc_tag(dt), .mem_req, .mem_addr, .mem_bytes, .mem_cap,
    .mem_unpriv, .mem_cap_level, .mem_ack, .mem_rdata, .mem_rtag, .wb_gpr_en, .wb_cap_en,
    .wb_vec_en, .wb_index, .wb_data, .wb_tag, .done, .fault);

  mem_partner mem_partner_i (.pclk, .presetn, .slow, .mem_req, .mem_addr, .mem_ack,
    .mem_rdata, .mem_rtag);

  // Fixed-seed xorshift source for stimulus.
  function automatic logic [63:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 7;
    seed ^= seed << 17;
    return seed;
  endfunction

  // One register transfer.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] w,
                     output logic [31:0] rv, output logic ev);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= w;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Compare register-side results.
  task automatic chk_reg(input logic [32:0] got, input logic [32:0] exp);
    chk_load(128'(got), 128'(exp));
  endtask

  // Compare load-side results.
  task automatic chk_load(input logic [127:0] got, input logic [127:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Print the verdict and stop.
  task automatic print_verdict();
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog against a hang.
  initial begin
    repeat (30000) @(posedge pclk);
    failures++;
    print_verdict();
  end

  // Reset values, random loads, enable gate, count.
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    for (int i = 0; i < 9; i++) begin
      apb(1'h0, 12'(i * 4), 32'h0, rd, er);
      chk_reg({er, rd}, {1'(i > 6), 32'(i == 0)});
    end
    apb(1'h1, 12'h008, 32'he, rd, er);
    for (int k = 0; k < 80; k++) begin
      @(posedge pclk);
      r = rnd();
      op <= 3'(r % 6);
      ces <= r[8];
      cen <= |r[11:9];
      fpe <= |r[13:12];
      el <= r[15:14];
      uao <= r[16];
      e2h <= r[17];
      tge <= r[18];
      rm <= r[23:19];
      imm <= r[32:24];
      {sg, wd, sh, dw} <= r[36:33];
      vsc <= 3'(r[39:37] % 5);
      dest <= r[44:40];
      slow <= r[45];
      bt <= |r[47:46];
      dt <= |r[49:48];
      bp <= {r[63:49], r[50] | r[51]};
      dp <= {r[62:48], r[49] | r[47]};
      r = rnd();
      ov <= {r[63:32], {16{r[15]}}, r[15:0]};
      gb <= {48'h1000, r[31:16]};
      cb <= {48'h1000, r[47:32]};
      hi <= r[0] ? 64'h1002_0000 : {48'h1000, r[63:48]};
      req_valid <= 1'h1;
      do @(posedge pclk); while (req_ready !== 1'h1);
      req_valid <= 1'h0;
      ib = (op == 1 || op == 3) ? !ces : ces;
      base = ib ? gb : cb;
      case ({sg, wd})
        2'h0: off = {32'h0, ov[31:0]};
        2'h2: off = {{32{ov[31]}}, ov[31:0]};
        default: off = ov;
      endcase
      off = (rm == 5'h1f) ? 64'h0 : off << sh;
      if (op == 1) off = {{51{imm[8]}}, imm, 4'h0};
      else if (op != 0) off = {{55{imm[8]}}, imm};
      nb = (op == 0) ? 5'h2 : (op == 4) ? (dw ? 5'h8 : 5'h4) : (op == 5) ? 5'(1 << vsc) : 5'h10;
      addr = base + off;
      ok = (ib ? dt & dp[0] : bt & bp[0]) && addr >= lo && addr + nb <= hi;
      ef = !cen || (op == 5 && !fpe) || !ok;
      ebit = !cen ? 4'h2 : (op == 5 && !fpe) ? 4'h8 : 4'h4;
      cap = op inside {3'h1, 3'h2, 3'h3};
      seen = 1'h0;
      n = 0;
      do begin
        @(posedge pclk);
        #1;
        n++;
        if (mem_req && !seen) chk_load({mem_addr, mem_bytes, mem_cap, mem_unpriv, mem_cap_level},
          {addr, nb, cap, op == 1 && !uao && (el == 1 || el == 2 && e2h && tge), el});
        seen |= mem_req;
        if (mem_req && mem_ack) {rtag, rdat} = {mem_rtag, mem_rdata};
      end while (done !== 1'h1 && n < 40);
      chk_load({done, fault, seen}, {1'h1, ef, !ef});
      case (op)
        3'h0: ed = dw ? {64'h0, {48{rdat[15]}}, rdat[15:0]} : {96'h0, {16{rdat[15]}}, rdat[15:0]};
        3'h4: ed = dw ? {64'h0, rdat[63:0]} : {96'h0, rdat[31:0]};
        3'h5: ed = rdat & ((128'h1 << (8 << vsc)) - 128'h1);
        default: ed = rdat;
      endcase
      if (!ef) begin
        cnt++;
        chk_load({wb_gpr_en, wb_cap_en, wb_vec_en, wb_index},
          {op == 0 || op == 4, cap, op == 5, dest});
        chk_load(wb_data, ed);
        if (cap) chk_load(wb_tag, rtag & (ib ? dt & dp[1] : bt & bp[1]));
      end else begin
        chk_load({wb_gpr_en, wb_cap_en, wb_vec_en}, 3'h0);
        apb(1'h0, 12'h004, 32'h0, rd, er);
        chk_reg({irq, rd[3:1]}, {1'h1, ebit[3:1]});
        apb(1'h1, 12'h008, 32'h0, rd, er);
        @(posedge pclk);
        #1;
        chk_reg(irq, 33'h0);
        apb(1'h1, 12'h008, 32'he, rd, er);
        apb(1'h1, 12'h004, 32'hf, rd, er);
        @(posedge pclk);
        #1;
        chk_reg(irq, 33'h0);
      end
    end
    apb(1'h1, 12'h000, 32'h0, rd, er);
    @(posedge pclk);
    req_valid <= 1'h1;
    bad = 1'h0;
    repeat (6) begin
      @(posedge pclk);
      #1;
      bad |= mem_req | done;
    end
    @(posedge pclk);
    req_valid <= 1'h0;
    chk_load(bad, 128'h0);
    apb(1'h1, 12'h000, 32'h1, rd, er);
    apb(1'h0, 12'h014, 32'h0, rd, er);
    chk_reg({er, rd}, {1'h0, 32'(cnt)});
    print_verdict();
  end
endmodule

`default_nettype wire

// ---- include/capability_load_pkg.sv ----
// Constants, encodings and register map for the capability load unit.
package capability_load_pkg;

  // Load operation codes presented with each request.
  typedef enum logic [2:0] {
    OP_LOAD_SIGNED_HALF_REG = 3'h0,
    OP_LOAD_CAP_UNPRIVILEGED = 3'h1,
    OP_LOAD_UNSCALED_CAP_ALT = 3'h2,
    OP_LOAD_UNSCALED_CAP_NORMAL = 3'h3,
    OP_LOAD_UNSCALED_INT = 3'h4,
    OP_LOAD_UNSCALED_VEC = 3'h5
  } load_op_t;

  // Sequencer states, Gray coded along idle, issue, wait, finish.
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ISSUE = 2'h1,
    ST_WAIT = 2'h3,
    ST_FINISH = 2'h2
  } load_state_t;

  // Offset extend selector, formed as sign bit then width bit.
  localparam logic [1:0] EXT_UNSIGNED_WORD = 2'h0;
  localparam logic [1:0] EXT_PLAIN_SHIFT = 2'h1;
  localparam logic [1:0] EXT_SIGNED_WORD = 2'h2;
  localparam logic [1:0] EXT_SIGNED_DWORD = 2'h3;

  // Field values and access sizes.
  localparam logic [4:0] ZERO_REGISTER = 5'h1f;
  localparam int HALF_SCALE = 1;
  localparam logic [7:0] BYTE_BASE_SIZE = 8'h08;
  localparam logic [7:0] VEC_HALF_SIZE = 8'h10;
  localparam logic [4:0] CAPABILITY_BYTE_SIZE = 5'h10;
  localparam int CAP_IMM_SCALE = 4;
  localparam logic [1:0] LEVEL_ONE = 2'h1;
  localparam logic [1:0] LEVEL_TWO = 2'h2;

  // Capability permission bit positions.
  localparam int LOAD_PERMISSION = 0;
  localparam int LOAD_CAP_PERMISSION = 1;
  localparam int PERM_WIDTH = 16;

  // APB register byte offsets.
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] INT_STATUS_OFFSET = 12'h004;
  localparam logic [11:0] INT_MASK_OFFSET = 12'h008;
  localparam logic [11:0] LAST_ADDR_LO_OFFSET = 12'h00c;
  localparam logic [11:0] LAST_ADDR_HI_OFFSET = 12'h010;
  localparam logic [11:0] LOAD_COUNT_OFFSET = 12'h014;
  localparam logic [11:0] UNIT_STATE_OFFSET = 12'h018;

  // Control and event field layout and reset values.
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int EVT_DONE = 0;
  localparam int EVT_CAP_DISABLED = 1;
  localparam int EVT_ADDR_FAULT = 2;
  localparam int EVT_FP_DISABLED = 3;
  localparam int EVT_WIDTH = 4;
  localparam logic [3:0] INT_MASK_RESET = 4'h0;

endpackage

// ---- src/capability_load_agu.sv ----
// Decode, address generation and execution of the capability aware loads.
//
// Operation
// RULE1: Alternate-base forms use integer base when execution state is 1, capability otherwise.
// RULE2: Normal-base capability load uses integer base when state is 0, capability when 1.
// RULE3: Signed halfword register load sign-extends the halfword into the integer destination.
// RULE4: Signed halfword access size is eight shifted left by scale one.
// RULE5: Doubleword class gives a 64-bit result, word class a 32-bit result.
// RULE6: Offset width bit 0 takes 32-bit register view, 1 the 64-bit view.
// RULE7: Extend selector 00 unsigned word, 01 shift, 10 signed word, 11 signed dword.
// RULE8: Shift bit 1 shifts offset left by one, 0 applies no shift.
// RULE9: Offset field 31 is the zero register giving zero; 0 to 30 are registers.
// RULE10: Address is base plus offset, checked for permission and size before reading.
// RULE11: Unprivileged load acts at lowest level when override clear at level 1 or host 2.
// RULE12: Unprivileged load always keeps capability restrictions of its real level.
// RULE13: Unprivileged load immediate is signed, scaled by 16, -4096 to 4080.
// RULE14: Unscaled forms sign-extend nine bit immediate as byte offset -256 to 255.
// RULE15: Loaded capabilities pass the squash step before reaching the destination.
// RULE16: Unscaled integer load zero-extends a 32 or 64 bit value into destination.
// RULE17: Unscaled vector load has five sizes 8 to 128 bits, 16-bit class uses 16.
// RULE18: Vector load needs floating point enabled and writes data unextended.
// RULE19: A failed enable or address check faults and leaves the destination unchanged.
`timescale 1ns/10ps
`default_nettype none

module capability_load_agu
  import capability_load_pkg::*;
#(
  parameter int ADDR_WIDTH = 64
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB register port.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // Processor state.
  input wire logic capability_exec_state,
  input wire logic user_access_override,
  input wire logic host_extension_enable,
  input wire logic trap_general_exceptions,
  input wire logic [1:0] exec_level,
  input wire logic caps_enabled,
  input wire logic fp_enabled,
  // Load request.
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [2:0] req_op,
  input wire logic [4:0] dest_field,
  input wire logic [4:0] offset_reg_field,
  input wire logic [8:0] nine_bit_immediate,
  input wire logic ext_sign_bit,
  input wire logic offset_width_bit,
  input wire logic shift_bit,
  input wire logic dword_class,
  input wire logic [2:0] vec_size_class,
  // Operand values read by the register files.
  input wire logic [ADDR_WIDTH-1:0] offset_reg_value,
  input wire logic [ADDR_WIDTH-1:0] base_gpr_value,
  input wire logic [ADDR_WIDTH-1:0] base_cap_addr,
  input wire logic [ADDR_WIDTH-1:0] base_cap_lower,
  input wire logic [ADDR_WIDTH-1:0] base_cap_upper,
  input wire logic [PERM_WIDTH-1:0] base_cap_perms,
  input wire logic base_cap_tag,
  // Default data capability guarding integer bases.
  input wire logic [ADDR_WIDTH-1:0] ddc_lower,
  input wire logic [ADDR_WIDTH-1:0] ddc_upper,
  input wire logic [PERM_WIDTH-1:0] ddc_perms,
  input wire logic ddc_tag,
  // Memory port.
  output logic mem_req,
  output logic [ADDR_WIDTH-1:0] mem_addr,
  output logic [4:0] mem_bytes,
  output logic mem_cap,
  output logic mem_unpriv,
  output logic [1:0] mem_cap_level,
  input wire logic mem_ack,
  input wire logic [127:0] mem_rdata,
  input wire logic mem_rtag,
  // Writeback and completion.
  output logic wb_gpr_en,
  output logic wb_cap_en,
  output logic wb_vec_en,
  output logic [4:0] wb_index,
  output logic [127:0] wb_data,
  output logic wb_tag,
  output logic done,
  output logic fault
);

  // Sign extension of the nine bit immediate, used by both immediate forms.
  function automatic logic [63:0] sext9(input logic [8:0] imm);
    sext9 = {{55{imm[8]}}, imm};
  endfunction

  // Register offset extension by selector, then optional shift.
  function automatic logic [63:0] extend_reg(input logic [63:0] v, input logic [1:0] sel,
                                             input logic sh);
    logic [63:0] e;
    e = 64'h0000_0000_0000_0000;
    case (sel)
      EXT_UNSIGNED_WORD: e = {32'h0000_0000, v[31:0]}; // RULE7 RULE6
      EXT_PLAIN_SHIFT: e = v; // RULE7 RULE6
      EXT_SIGNED_WORD: e = {{32{v[31]}}, v[31:0]}; // RULE7
      default: e = v; // RULE7
    endcase
    extend_reg = sh ? (e << HALF_SCALE) : e; // RULE8
  endfunction

  load_state_t state;
  load_state_t next_state;
  logic [31:0] ctrl;
  logic [EVT_WIDTH-1:0] int_status;
  logic [EVT_WIDTH-1:0] int_mask;
  logic [31:0] load_count;
  logic [63:0] last_addr;
  load_op_t op;
  logic [4:0] dest;
  logic dword;
  logic [2:0] vclass;
  logic use_gpr_base;
  logic [63:0] addr;
  logic [4:0] nbytes;
  logic unpriv;
  logic [PERM_WIDTH-1:0] chk_perms;
  logic chk_tag;
  logic [63:0] chk_lower;
  logic [63:0] chk_upper;

  // Request decode.
  wire load_op_t dec_op = load_op_t'(req_op);
  wire take = req_valid && req_ready && ctrl[CTRL_ENABLE_BIT];
  wire is_alt = (dec_op == OP_LOAD_SIGNED_HALF_REG) || (dec_op == OP_LOAD_UNSCALED_CAP_ALT)
                || (dec_op == OP_LOAD_UNSCALED_INT) || (dec_op == OP_LOAD_UNSCALED_VEC);
  wire dec_gpr_base = is_alt ? capability_exec_state : !capability_exec_state; // RULE1 RULE2
  wire [63:0] dec_base = dec_gpr_base ? base_gpr_value : base_cap_addr;
  wire [63:0] reg_val = (offset_reg_field == ZERO_REGISTER) ? 64'h0000_0000_0000_0000
                        : offset_reg_value; // RULE9
  wire [63:0] reg_off = extend_reg(reg_val, {ext_sign_bit, offset_width_bit}, shift_bit);
  wire [63:0] cap_imm_off = sext9(nine_bit_immediate) << CAP_IMM_SCALE; // RULE13
  wire [63:0] dec_off = (dec_op == OP_LOAD_SIGNED_HALF_REG) ? reg_off
                        : (dec_op == OP_LOAD_CAP_UNPRIVILEGED) ? cap_imm_off
                        : sext9(nine_bit_immediate); // RULE14
  wire [7:0] half_bits = BYTE_BASE_SIZE << HALF_SCALE; // RULE4
  wire [4:0] vec_bytes = 5'(8'(BYTE_BASE_SIZE << vec_size_class) >> 3); // RULE17
  wire [4:0] dec_bytes = (dec_op == OP_LOAD_SIGNED_HALF_REG) ? 5'(half_bits >> 3)
                         : (dec_op == OP_LOAD_UNSCALED_INT) ? (dword_class ? 5'h08 : 5'h04)
                         : (dec_op == OP_LOAD_UNSCALED_VEC) ? vec_bytes
                         : CAPABILITY_BYTE_SIZE;
  wire at_one = exec_level == LEVEL_ONE;
  wire at_two = (exec_level == LEVEL_TWO) && host_extension_enable && trap_general_exceptions;
  wire dec_unpriv = (dec_op == OP_LOAD_CAP_UNPRIVILEGED) && !user_access_override
                    && (at_one || at_two); // RULE11
  wire dec_is_cap = (dec_op == OP_LOAD_CAP_UNPRIVILEGED) || (dec_op == OP_LOAD_UNSCALED_CAP_ALT)
                    || (dec_op == OP_LOAD_UNSCALED_CAP_NORMAL);

  // Pre-access checks, evaluated in the issue state before any read.
  wire [64:0] end_addr = {1'b0, addr} + {60'h0, nbytes};
  wire bounds_ok = (addr >= chk_lower) && (end_addr <= {1'b0, chk_upper});
  wire check_ok = chk_tag && chk_perms[LOAD_PERMISSION] && bounds_ok; // RULE10
  wire cap_off = !caps_enabled; // RULE19
  wire fp_off = (op == OP_LOAD_UNSCALED_VEC) && !fp_enabled; // RULE18
  wire issue_fault = cap_off || fp_off || !check_ok; // RULE19

  // Result formatting.
  wire [127:0] sq_value;
  wire sq_tag;
  wire [63:0] half_sext = {{48{mem_rdata[15]}}, mem_rdata[15:0]}; // RULE3
  wire [63:0] half_res = dword ? half_sext : {32'h0000_0000, half_sext[31:0]}; // RULE5
  wire [63:0] int_res = dword ? mem_rdata[63:0] : {32'h0000_0000, mem_rdata[31:0]}; // RULE16
  wire [127:0] vec_mask = (vclass >= 3'h4) ? {128{1'b1}}
                          : ({128{1'b0}} | ((128'h1 << (8 << vclass)) - 128'h1));
  wire [127:0] vec_res = mem_rdata & vec_mask; // RULE18

  post_load_squash squash_u (
    .loaded_value(mem_rdata),
    .loaded_tag(mem_rtag),
    .base_tag(chk_tag),
    .base_perms(chk_perms),
    .squashed_value(sq_value),
    .squashed_tag(sq_tag)
  );

  // Sequencer next state.
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (take) next_state = ST_ISSUE;
      ST_ISSUE: next_state = issue_fault ? ST_FINISH : ST_WAIT;
      ST_WAIT: if (mem_ack) next_state = ST_FINISH;
      default: next_state = ST_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state <= ST_IDLE;
    else state <= next_state;
  end

  // Capture of the decoded request.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op <= OP_LOAD_SIGNED_HALF_REG;
      dest <= 5'h00;
      dword <= 1'b0;
      vclass <= 3'h0;
      use_gpr_base <= 1'b0;
      addr <= 64'h0000_0000_0000_0000;
      nbytes <= 5'h00;
      unpriv <= 1'b0;
    end else if (take) begin
      op <= dec_op;
      dest <= dest_field;
      dword <= dword_class;
      vclass <= vec_size_class;
      use_gpr_base <= dec_gpr_base;
      addr <= dec_base + dec_off; // RULE10
      nbytes <= dec_bytes;
      unpriv <= dec_unpriv;
    end
  end

  // Authorising capability: the base capability, or the default one for integer bases.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_perms <= '0;
      chk_tag <= 1'b0;
      chk_lower <= 64'h0000_0000_0000_0000;
      chk_upper <= 64'h0000_0000_0000_0000;
    end else if (take) begin
      chk_perms <= dec_gpr_base ? ddc_perms : base_cap_perms;
      chk_tag <= dec_gpr_base ? ddc_tag : base_cap_tag;
      chk_lower <= dec_gpr_base ? ddc_lower : base_cap_lower;
      chk_upper <= dec_gpr_base ? ddc_upper : base_cap_upper;
    end
  end

  // Memory request, raised only after the checks pass.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req <= 1'b0;
      mem_addr <= 64'h0000_0000_0000_0000;
      mem_bytes <= 5'h00;
      mem_cap <= 1'b0;
      mem_unpriv <= 1'b0;
      mem_cap_level <= 2'h0;
    end else if (state == ST_ISSUE && !issue_fault) begin
      mem_req <= 1'b1; // RULE10
      mem_addr <= addr;
      mem_bytes <= nbytes;
      mem_cap <= (op == OP_LOAD_CAP_UNPRIVILEGED) || (op == OP_LOAD_UNSCALED_CAP_ALT)
                 || (op == OP_LOAD_UNSCALED_CAP_NORMAL);
      mem_unpriv <= unpriv; // RULE11
      mem_cap_level <= exec_level; // RULE12
    end else if (mem_ack) begin
      mem_req <= 1'b0;
    end
  end

  // Writeback, held back entirely when a check fails.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wb_gpr_en <= 1'b0;
      wb_cap_en <= 1'b0;
      wb_vec_en <= 1'b0;
      wb_index <= 5'h00;
      wb_data <= '0;
      wb_tag <= 1'b0;
    end else if (state == ST_WAIT && mem_ack) begin
      wb_gpr_en <= (op == OP_LOAD_SIGNED_HALF_REG) || (op == OP_LOAD_UNSCALED_INT);
      wb_cap_en <= mem_cap; // RULE15
      wb_vec_en <= op == OP_LOAD_UNSCALED_VEC;
      wb_index <= dest;
      if (op == OP_LOAD_SIGNED_HALF_REG) wb_data <= {64'h0, half_res}; // RULE3
      else if (op == OP_LOAD_UNSCALED_INT) wb_data <= {64'h0, int_res}; // RULE16
      else if (op == OP_LOAD_UNSCALED_VEC) wb_data <= vec_res; // RULE18
      else wb_data <= sq_value; // RULE15
      wb_tag <= mem_cap && sq_tag; // RULE15
    end else begin
      wb_gpr_en <= 1'b0;
      wb_cap_en <= 1'b0;
      wb_vec_en <= 1'b0;
    end
  end

  // Completion pulses, busy flag, address log and count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= 1'b0;
      fault <= 1'b0;
      req_ready <= 1'b1;
      last_addr <= 64'h0000_0000_0000_0000;
      load_count <= 32'h0000_0000;
    end else begin
      done <= (state == ST_WAIT && mem_ack) || (state == ST_ISSUE && issue_fault);
      fault <= state == ST_ISSUE && issue_fault; // RULE19
      req_ready <= (next_state == ST_IDLE);
      if (state == ST_ISSUE) last_addr <= addr;
      if (state == ST_WAIT && mem_ack) load_count <= load_count + 32'h0000_0001;
    end
  end

  // Event sources feeding the sticky status bits.
  wire [EVT_WIDTH-1:0] events;
  assign events[EVT_DONE] = state == ST_WAIT && mem_ack;
  assign events[EVT_CAP_DISABLED] = state == ST_ISSUE && cap_off;
  assign events[EVT_ADDR_FAULT] = state == ST_ISSUE && !cap_off && !fp_off && !check_ok;
  assign events[EVT_FP_DISABLED] = state == ST_ISSUE && !cap_off && fp_off;

  // APB decode: the access completes one cycle into the access phase.
  wire apb_access = psel && penable && !pready;
  wire apb_commit = psel && penable && pready;
  wire hit_ctrl = paddr == CTRL_OFFSET;
  wire hit_status = paddr == INT_STATUS_OFFSET;
  wire hit_mask = paddr == INT_MASK_OFFSET;
  wire hit_lo = paddr == LAST_ADDR_LO_OFFSET;
  wire hit_hi = paddr == LAST_ADDR_HI_OFFSET;
  wire hit_count = paddr == LOAD_COUNT_OFFSET;
  wire hit_state = paddr == UNIT_STATE_OFFSET;
  wire mapped = hit_ctrl || hit_status || hit_mask || hit_lo || hit_hi || hit_count || hit_state;
  wire wr_commit = apb_commit && pwrite && mapped;
  wire [EVT_WIDTH-1:0] w1c = (wr_commit && hit_status) ? pwdata[EVT_WIDTH-1:0] : '0;
  wire [31:0] read_mux;
  assign read_mux = hit_ctrl ? ctrl
                    : hit_status ? {28'h000_0000, int_status}
                    : hit_mask ? {28'h000_0000, int_mask}
                    : hit_lo ? last_addr[31:0]
                    : hit_hi ? last_addr[63:32]
                    : hit_count ? load_count
                    : hit_state ? {30'h0000_0000, state}
                    : 32'h0000_0000;

  // APB handshake and read data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_access;
      pslverr <= apb_access && !mapped;
      prdata <= (apb_access && !pwrite) ? read_mux : 32'h0000_0000;
    end
  end

  // Software registers; a new event wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      int_mask <= INT_MASK_RESET;
      int_status <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_commit && hit_ctrl) ctrl <= {31'h0000_0000, pwdata[CTRL_ENABLE_BIT]};
      if (wr_commit && hit_mask) int_mask <= pwdata[EVT_WIDTH-1:0];
      int_status <= (int_status & ~w1c) | events;
      irq <= |(((int_status & ~w1c) | events) & int_mask);
    end
  end

endmodule

`default_nettype wire

// ---- src/post_load_squash.sv ----
// Squash step applied to every capability read from memory.
`timescale 1ns/10ps
`default_nettype none

module post_load_squash
  import capability_load_pkg::*;
(
  // Loaded capability.
  input wire logic [127:0] loaded_value,
  input wire logic loaded_tag,
  // Base capability that authorised the load.
  input wire logic base_tag,
  input wire logic [PERM_WIDTH-1:0] base_perms,
  // Squashed result.
  output logic [127:0] squashed_value,
  output logic squashed_tag
);

  // The tag survives only if the base is valid and may load capabilities.
  assign squashed_value = loaded_value;
  assign squashed_tag = loaded_tag & base_tag & base_perms[LOAD_CAP_PERMISSION];

endmodule

`default_nettype wire
